// ---- pmmo_pkg.sv ----
// Package for the power module miscellaneous options block.
// Assumes a command decoder upstream that presents command code and data words.
package pmmo_pkg;
    localparam logic [7:0]  CMD_MISC_OPTIONS    = 8'hF0;
    localparam logic [7:0]  CMD_STORE_ALL       = 8'h11;
    localparam logic [7:0]  CMD_CLEAR_FAULTS    = 8'h03;
    localparam logic [7:0]  CMD_VOUT_COMMAND    = 8'h21;
    localparam logic [7:0]  CMD_ON_OFF_CONFIG   = 8'h02;
    localparam logic [15:0] MISC_RESET          = 16'h0193;
    localparam logic [15:0] MISC_WRITE_MASK     = 16'h01D7;
    localparam int          BIT_OV_REL_SEL      = 0;
    localparam int          BIT_TRIM_LO         = 1;
    localparam int          BIT_LS_EN           = 4;
    localparam int          BIT_SYNC_OUT        = 6;
    localparam int          BIT_SYNC_IN         = 7;
    localparam int          BIT_SYNC_MASK       = 8;
    localparam int          ON_OFF_POL_BIT      = 1;
    localparam logic [7:0]  ON_OFF_RESET        = 8'h17;
    localparam logic [15:0] VOUT_SCALE          = 16'h0200;
    localparam logic [15:0] VOUT_RESET          = 16'h0266;
    // Release threshold 0.2 V expressed in the same 1/512 V units as the set point
    localparam logic [15:0] FB_RELEASE_CODE     = 16'h0066;
    localparam int          PG_LO_PCT           = 95;
    localparam int          PG_HI_PCT           = 105;
    localparam logic [2:0]  TRIM_NONE           = 3'h0;

    typedef enum logic [1:0] {
        PMMO_OV_IGNORE,
        PMMO_OV_SHUTDOWN,
        PMMO_OV_RESTART,
        PMMO_OV_RETRY
    } pmmo_ov_action_t;

    typedef struct packed {
        logic        valid;
        logic [7:0]  code;
        logic        write;
        logic [15:0] data;
    } pmmo_cmd_t;

    typedef struct packed {
        logic       low_side_hold;
        logic       level_shifter_on;
        logic [2:0] trim_sel;
        logic       sync_out_en;
        logic       sync_in_en;
    } pmmo_ctrl_t;
endpackage

// ---- pmmo_misc_options.sv ----
// Miscellaneous options register and its effects on power stage control.
// Assumes commands are decoded on ref_clk_i; the on/off, sync and free clock pins pass a two-flop sync here.
`timescale 1ns/1ps
`default_nettype none
module pmmo_misc_options (
    input  wire logic                      ref_clk_i,
    input  wire logic                      rst_i,
    input  wire pmmo_pkg::pmmo_cmd_t       cmd_i,
    input  wire pmmo_pkg::pmmo_ov_action_t overvoltage_fault_action_i,
    input  wire logic                      debug_limit_override_i,
    input  wire logic                      cmd_data_invalid_i,
    input  wire logic [15:0]               nvm_misc_i,
    input  wire logic                      nvm_restore_i,
    input  wire logic                      overvoltage_detect_i,
    input  wire logic [15:0]               feedback_sense_pin_i,
    input  wire logic [15:0]               vout_sense_i,
    input  wire logic                      on_off_control_pin_i,
    input  wire logic                      driver_enable_i,
    input  wire logic                      startup_begin_i,
    input  wire logic                      disabled_state_i,
    input  wire logic                      free_clock_i,
    input  wire logic                      sync_pin_i,
    input  wire logic                      sync_fault_i,
    output logic [15:0]                    rd_data_o,
    output logic                           nvm_store_o,
    output logic [15:0]                    nvm_data_o,
    output pmmo_pkg::pmmo_ctrl_t           ctrl_o,
    output logic                           sync_pin_o,
    output logic                           sync_pin_oe_o,
    output logic                           switch_clock_o,
    output logic                           sync_fault_status_o,
    output logic                           sync_fault_response_o,
    output logic                           invalid_data_flag_o,
    output logic                           convert_enable_o,
    output logic                           power_good_output_o,
    output logic                           power_good_output_oe_o
);
    import pmmo_pkg::*;

    default clocking ast_cb @(posedge ref_clk_i);
    endclocking
    default disable iff (rst_i);

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [2:0] trim_decode(input logic [1:0] f);
        // Threshold step in 12.5% units, two's complement
        case (f)
            2'b00:   trim_decode = TRIM_NONE;
            2'b01:   trim_decode = 3'h1;
            2'b10:   trim_decode = 3'h6;
            2'b11:   trim_decode = 3'h7;
            default: trim_decode = TRIM_NONE;
        endcase
    endfunction

    function automatic logic [22:0] pct(input logic [15:0] v, input int p);
        pct = 23'(v) * 23'(p);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers: first stage is read only by the second
    logic [2:0] pin_s1_q;
    logic [2:0] pin_s2_q;
    always_ff @(posedge ref_clk_i) begin
        pin_s1_q <= {on_off_control_pin_i, sync_pin_i, free_clock_i};
        pin_s2_q <= pin_s1_q;
    end
    wire on_off_pin_s = pin_s2_q[2];
    wire sync_pin_s   = pin_s2_q[1];
    wire free_clk_s   = pin_s2_q[0];

    ////////////////////////////////////////////////////////////////////////////
    logic [15:0] misc_q;
    logic [7:0]  on_off_cfg_q;
    logic [15:0] vout_cmd_q;
    wire wr_hit   = cmd_i.valid && cmd_i.write;
    wire wr_misc  = wr_hit && (cmd_i.code == CMD_MISC_OPTIONS);
    wire wr_onoff = wr_hit && (cmd_i.code == CMD_ON_OFF_CONFIG);
    wire wr_vout  = wr_hit && (cmd_i.code == CMD_VOUT_COMMAND);
    wire do_store = cmd_i.valid && (cmd_i.code == CMD_STORE_ALL);
    wire do_clear = cmd_i.valid && (cmd_i.code == CMD_CLEAR_FAULTS);
    wire [15:0] misc_d = (cmd_i.data & MISC_WRITE_MASK) | (misc_q & ~MISC_WRITE_MASK);

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            misc_q <= MISC_RESET;
        end else if (nvm_restore_i) begin
            misc_q <= nvm_misc_i & MISC_WRITE_MASK;
        end else if (wr_misc) begin
            misc_q <= misc_d;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            on_off_cfg_q <= ON_OFF_RESET;
            vout_cmd_q   <= VOUT_RESET;
        end else begin
            if (wr_onoff) begin
                on_off_cfg_q <= cmd_i.data[7:0];
            end
            // Host scales voltage by VOUT_SCALE before sending
            if (wr_vout) begin
                vout_cmd_q <= cmd_i.data;
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            nvm_store_o         <= 1'b0;
            nvm_data_o          <= 16'h0000;
            rd_data_o           <= 16'h0000;
            invalid_data_flag_o <= 1'b0;
        end else begin
            nvm_store_o <= do_store;
            nvm_data_o  <= misc_q;
            rd_data_o   <= misc_q;
            if (wr_hit && cmd_data_invalid_i && !debug_limit_override_i) begin
                invalid_data_flag_o <= 1'b1;
            end else if (do_clear) begin
                invalid_data_flag_o <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Low-side latch on overvoltage
    wire ov_latch   = overvoltage_detect_i && (overvoltage_fault_action_i != PMMO_OV_IGNORE);
    wire rel_sel0   = startup_begin_i || (do_clear && disabled_state_i);
    wire rel_sel1   = feedback_sense_pin_i < FB_RELEASE_CODE;
    wire ls_release = misc_q[BIT_OV_REL_SEL] ? rel_sel1 : rel_sel0;
    logic ls_hold_q;
    logic drv_en_q;
    logic ls_en_q;
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            ls_hold_q <= 1'b0;
            drv_en_q  <= 1'b0;
            ls_en_q   <= 1'b0;
        end else begin
            drv_en_q <= driver_enable_i;
            if (ov_latch) begin
                ls_hold_q <= 1'b1;
            end else if (ls_release) begin
                ls_hold_q <= 1'b0;
            end
            // Sampled only on the enable edge so a mid-run write cannot glitch the loop
            if (driver_enable_i && !drv_en_q) begin
                ls_en_q <= misc_q[BIT_LS_EN];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sync pin, conversion enable and power good
    wire sync_out = misc_q[BIT_SYNC_OUT];
    wire sync_in  = misc_q[BIT_SYNC_IN] && !sync_out;
    wire on_pol   = on_off_cfg_q[ON_OFF_POL_BIT];
    wire [22:0] v_x100 = pct(vout_sense_i, 100);
    wire pg_in_win = (v_x100 >= pct(vout_cmd_q, PG_LO_PCT)) && (v_x100 <= pct(vout_cmd_q, PG_HI_PCT));
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            ctrl_o                 <= '0;
            sync_pin_o             <= 1'b0;
            sync_pin_oe_o          <= 1'b0;
            switch_clock_o         <= 1'b0;
            sync_fault_status_o    <= 1'b0;
            sync_fault_response_o  <= 1'b0;
            convert_enable_o       <= 1'b0;
            power_good_output_o    <= 1'b0;
            power_good_output_oe_o <= 1'b1;
        end else begin
            ctrl_o.low_side_hold    <= ls_hold_q;
            // Gated by the delayed enable so a stale captured bit never shows at the enable edge
            ctrl_o.level_shifter_on <= ls_en_q && drv_en_q;
            ctrl_o.trim_sel         <= trim_decode(misc_q[BIT_TRIM_LO+:2]);
            ctrl_o.sync_out_en      <= sync_out;
            ctrl_o.sync_in_en       <= sync_in;
            sync_pin_o              <= sync_out && free_clk_s;
            sync_pin_oe_o           <= sync_out;
            switch_clock_o          <= sync_in ? sync_pin_s : free_clk_s;
            sync_fault_status_o     <= sync_fault_i && !misc_q[BIT_SYNC_MASK];
            sync_fault_response_o   <= sync_fault_i && !misc_q[BIT_SYNC_MASK];
            convert_enable_o        <= on_pol ? on_off_pin_s : !on_off_pin_s;
            power_good_output_o     <= 1'b0;
            power_good_output_oe_o  <= !pg_in_win;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    AST_STORE: assert property (do_store |=> nvm_store_o && nvm_data_o == $past(misc_q))
        else $error("store missed");
    AST_OV_LATCH: assert property (ov_latch |=> ls_hold_q)
        else $error("low side not latched");
    AST_HOLD0: assert property (ls_hold_q && !misc_q[BIT_OV_REL_SEL] && !rel_sel0 |=> ls_hold_q)
        else $error("early release");
    sequence s_fb_low;
        ls_hold_q && misc_q[BIT_OV_REL_SEL] && rel_sel1 && !ov_latch;
    endsequence
    sequence s_released;
        !ls_hold_q ##1 !ctrl_o.low_side_hold;
    endsequence
    AST_REL1: assert property (s_fb_low |=> s_released)
        else $error("no release");
    AST_TRIM: assert property (misc_q[BIT_TRIM_LO+:2] == 2'b10 |=> ctrl_o.trim_sel == 3'h6)
        else $error("trim decode");
    AST_LS_EN: assert property (ctrl_o.level_shifter_on |-> $past(ls_en_q))
        else $error("shifter on without bit");
    AST_LS_GATE: assert property (ctrl_o.level_shifter_on |-> $past(drv_en_q))
        else $error("shifter on before capture");
    AST_LS_CAP: assert property (drv_en_q && driver_enable_i |=> $stable(ls_en_q))
        else $error("shifter bit changed");
    AST_SYNC_OUT: assert property (sync_out |=> sync_pin_oe_o)
        else $error("sync out not driven");
    AST_SYNC_REL: assert property (!sync_out |=> !sync_pin_oe_o && !sync_pin_o)
        else $error("sync pin driven unforced");
    AST_SYNC_IN: assert property (sync_in |=> switch_clock_o == $past(sync_pin_s))
        else $error("switch clock not from sync pin");
    AST_MASK: assert property (misc_q[BIT_SYNC_MASK] |=> !sync_fault_status_o && !sync_fault_response_o)
        else $error("masked fault seen");
    AST_ONOFF_LOW: assert property (!on_pol && !on_off_pin_s |=> convert_enable_o)
        else $error("active low pin ignored");
    AST_PG: assert property (!pg_in_win |=> power_good_output_oe_o)
        else $error("pg released out of window");
    AST_RD_ZERO: assert property ((rd_data_o & ~MISC_WRITE_MASK) == 16'h0000)
        else $error("unused bits read nonzero");
    AST_IVD: assert property (debug_limit_override_i && !invalid_data_flag_o |=> !invalid_data_flag_o)
        else $error("flag under override");
endmodule
`default_nettype wire

// ---- pmmo_host_model.sv ----
// Host side model: issues one-cycle command words into the options block.
// Assumes the bench calls send and set_vout from its main sequence.
`timescale 1ns/1ps
`default_nettype none
module pmmo_host_model (
    input  wire logic                clk_i,
    output var pmmo_pkg::pmmo_cmd_t  cmd_o
);
    import pmmo_pkg::*;
    initial cmd_o = '0;
    // After the taking edge the fields show a scrambled word, never a stale copy
    task automatic send(input logic [7:0] code, input logic wr, input logic [15:0] data);
        @(posedge clk_i);
        #1 cmd_o = '{valid: 1'b1, code: code, write: wr, data: data};
        @(posedge clk_i);
        #1 cmd_o = '{valid: 1'b0, code: ~code, write: ~wr, data: ~data};
    endtask
    // Output voltage word is the target in volts times 512
    task automatic set_vout(input int mv);
        send(CMD_VOUT_COMMAND, 1'b1, 16'(mv * VOUT_SCALE / 1000));
    endtask
endmodule
`default_nettype wire

// ---- tb_top.sv ----
// Self-checking bench for the miscellaneous options block.
// Assumes the package and the host model are compiled before this file.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import pmmo_pkg::*;
    typedef struct packed {logic [15:0] wr; logic [15:0] rd; logic [2:0] trim; logic so; logic si;} pmmo_row_t;
    logic            clk = 1'b0, rst = 1'b1, fclk = 1'b1, ovd = 1'b0, dbg = 1'b0, inv = 1'b0;
    logic            onp = 1'b1, drv = 1'b0, stb = 1'b0, dis = 1'b0, sfl = 1'b0, spi = 1'b0, nvr = 1'b0;
    pmmo_ov_action_t act = PMMO_OV_SHUTDOWN;
    logic [15:0]     fb = 16'h0000, vs = 16'h0000, rd, nvd;
    pmmo_cmd_t       cmd;
    pmmo_ctrl_t      ctl;
    logic            nvs, spo, spoe, swc, sfs, sfr, ivf, cen, pgo, pgoe;
    int              n_failures = 0, n_compared = 0;
    pmmo_row_t       rows [5] = '{'{16'h0000, 16'h0000, 3'h0, 1'b0, 1'b0}, '{16'h0002, 16'h0002, 3'h1, 1'b0, 1'b0},
        '{16'h0004, 16'h0004, 3'h6, 1'b0, 1'b0}, '{16'h0046, 16'h0046, 3'h7, 1'b1, 1'b0},
        '{16'hFFBF, 16'h0197, 3'h7, 1'b0, 1'b1}};
    // Set point 0x0200: window edges at 95% and 105% fall between these pairs
    logic [15:0]     pv [4] = '{16'h0200, 16'h01E6, 16'h021A, 16'h01E7};
    logic            pe [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
    always #2.5 clk = ~clk;
    pmmo_host_model host (.clk_i(clk), .cmd_o(cmd));
    pmmo_misc_options DUT (
        .ref_clk_i(clk), .rst_i(rst), .cmd_i(cmd), .overvoltage_fault_action_i(act),
        .debug_limit_override_i(dbg), .cmd_data_invalid_i(inv), .nvm_misc_i(16'hFFFF),
        .nvm_restore_i(nvr), .overvoltage_detect_i(ovd), .feedback_sense_pin_i(fb), .vout_sense_i(vs),
        .on_off_control_pin_i(onp), .driver_enable_i(drv), .startup_begin_i(stb), .disabled_state_i(dis),
        .free_clock_i(fclk), .sync_pin_i(spi), .sync_fault_i(sfl), .rd_data_o(rd), .nvm_store_o(nvs),
        .nvm_data_o(nvd), .ctrl_o(ctl), .sync_pin_o(spo), .sync_pin_oe_o(spoe), .switch_clock_o(swc),
        .sync_fault_status_o(sfs), .sync_fault_response_o(sfr), .invalid_data_flag_o(ivf),
        .convert_enable_o(cen), .power_good_output_o(pgo), .power_good_output_oe_o(pgoe));
    ////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        n_compared++;
        if (g !== e) begin
            n_failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic finish_test();
        $display("compared=%0d failures=%0d", n_compared, n_failures);
        if (n_failures == 0 && n_compared > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // Whole run is under two hundred cycles, so this only trips on a hang
    initial begin
        #20us;
        n_failures++;
        finish_test();
    end
    ////////////////////////////////////////////////////////////////
    initial begin
        tick(20);
        rst = 1'b0;
        tick(4);
        chk(rd, MISC_RESET);
        chk(cen, 1'b1);
        foreach (rows[i]) begin
            host.send(CMD_MISC_OPTIONS, 1'b1, rows[i].wr);
            tick(3);
            chk(rd, rows[i].rd);
            chk(ctl.trim_sel, rows[i].trim);
            chk(ctl.sync_out_en, rows[i].so);
            chk(spoe, rows[i].so);
            chk(ctl.sync_in_en, rows[i].si);
            chk({spo, swc}, {rows[i].so, ~rows[i].si});
        end
        host.send(CMD_STORE_ALL, 1'b1, 16'h0000);
        chk(nvs, 1'b1);
        chk(nvd, 16'h0197);
        tick(1);
        chk(nvs, 1'b0);
        sfl = 1'b1;
        tick(4);
        chk({sfs, sfr}, 2'b00);
        host.send(CMD_MISC_OPTIONS, 1'b1, 16'h0010);
        tick(3);
        chk({sfs, sfr}, 2'b11);
        sfl = 1'b0;
        drv = 1'b1;
        tick(3);
        chk(ctl.level_shifter_on, 1'b1);
        host.send(CMD_MISC_OPTIONS, 1'b1, 16'h0000);
        tick(3);
        chk(ctl.level_shifter_on, 1'b1);
        drv = 1'b0;
        tick(2);
        drv = 1'b1;
        tick(3);
        chk(ctl.level_shifter_on, 1'b0);
        // Select 0: held through low feedback, freed by startup, then by clear while disabled
        ovd = 1'b1;
        tick(2);
        ovd = 1'b0;
        tick(3);
        chk(ctl.low_side_hold, 1'b1);
        stb = 1'b1;
        tick(1);
        stb = 1'b0;
        tick(3);
        chk(ctl.low_side_hold, 1'b0);
        ovd = 1'b1;
        tick(2);
        ovd = 1'b0;
        host.send(CMD_CLEAR_FAULTS, 1'b1, 16'h0000);
        tick(3);
        chk(ctl.low_side_hold, 1'b1);
        dis = 1'b1;
        host.send(CMD_CLEAR_FAULTS, 1'b1, 16'h0000);
        tick(3);
        chk(ctl.low_side_hold, 1'b0);
        dis = 1'b0;
        host.send(CMD_MISC_OPTIONS, 1'b1, 16'h0001);
        fb = 16'h0066;
        ovd = 1'b1;
        tick(2);
        ovd = 1'b0;
        tick(3);
        chk(ctl.low_side_hold, 1'b1);
        fb = 16'h0065;
        tick(3);
        chk(ctl.low_side_hold, 1'b0);
        act = PMMO_OV_IGNORE;
        ovd = 1'b1;
        tick(3);
        chk(ctl.low_side_hold, 1'b0);
        ovd = 1'b0;
        host.send(CMD_ON_OFF_CONFIG, 1'b1, 16'h0015);
        onp = 1'b0;
        tick(4);
        chk(cen, 1'b1);
        onp = 1'b1;
        tick(4);
        chk(cen, 1'b0);
        host.set_vout(1000);
        foreach (pv[i]) begin
            vs = pv[i];
            tick(3);
            chk({pgo, pgoe}, {1'b0, pe[i]});
        end
        inv = 1'b1;
        host.send(CMD_MISC_OPTIONS, 1'b1, 16'h0000);
        tick(2);
        chk(ivf, 1'b1);
        inv = 1'b0;
        host.send(CMD_CLEAR_FAULTS, 1'b1, 16'h0000);
        tick(2);
        chk(ivf, 1'b0);
        dbg = 1'b1;
        inv = 1'b1;
        host.send(CMD_MISC_OPTIONS, 1'b1, 16'h0000);
        tick(2);
        chk(ivf, 1'b0);
        // Clock out alone, then sync in alone; pin levels pass two flops and the output flop
        host.send(CMD_MISC_OPTIONS, 1'b1, 16'h0040);
        fclk = 1'b0;
        spi = 1'b1;
        tick(4);
        chk({spo, spoe, swc}, 3'b010);
        fclk = 1'b1;
        spi = 1'b0;
        tick(4);
        chk({spo, spoe, swc}, 3'b111);
        host.send(CMD_MISC_OPTIONS, 1'b1, 16'h0080);
        tick(4);
        chk({spo, spoe, swc}, 3'b000);
        spi = 1'b1;
        fclk = 1'b0;
        tick(4);
        chk({spo, spoe, swc}, 3'b001);
        nvr = 1'b1;
        tick(1);
        nvr = 1'b0;
        tick(2);
        chk(rd, 16'h01D7);
        rst = 1'b1;
        tick(3);
        rst = 1'b0;
        tick(2);
        chk(rd, MISC_RESET);
        chk(cen, 1'b1);
        finish_test();
    end
endmodule
`default_nettype wire
